// File: design/pmh_cmd_handler.sv
// Functional notes
// - mode query answers with present mode code
// - go-online in remote selects serial mode
// - online via RS-232C gives 232 mode, answer
// - online via RS-485 gives 485 mode, answer
// - go-offline in serial mode returns to remote
// - inapplicable online/offline keeps mode, still answers
// - panel selector forces local or remote mode
// - valid start accelerates pump, accel answer
// - valid stop decelerates pump, decel answer
// - reset silences sounding buzzer, buzzer-off answer
// - silent buzzer: reset clears the alarm
// - cause gone: cleared; else buzzer, persists answer
// - persists answer carries two-character alarm code
// - inapplicable operation gets invalid answer, no action
// - operation from unselected port is invalid
`timescale 1ns/1ps
module pmh_cmd_handler (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_code,
    input  wire logic        cmd_port,
    output logic             cmd_ready_ff,
    output logic             ans_valid_ff,
    output logic [3:0]       ans_code_ff,
    output logic [15:0]      ans_sub_ff,
    input  wire logic        panel_local_sel,
    input  wire logic        pump_accel,
    input  wire logic        pump_normal,
    input  wire logic        fail_active,
    input  wire logic        fail_cause,
    input  wire logic [15:0] fail_code,
    input  wire logic        alarm_event,
    output logic             start_req_ff,
    output logic             stop_req_ff,
    output logic             alarm_clear_ff,
    output logic             buzzer_on_ff,
    output logic [1:0]       op_mode_ff
);

    // ----------------------------------------------------------------
    // panel selector synchroniser and change detect
    // ----------------------------------------------------------------
    logic               sel_local_sync;
    logic               sel_local_ff;
    logic [1:0]         sel_seen_ff;
    pmh_mode_if         mif ();

    pmh_sync #(
        .W (1)
    ) u_sel_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in (panel_local_sel),
        .sync_out (sel_local_sync)
    );

    // edges count only once both sync stages and the delay stage hold the pin,
    // so a selector already at local during reset is not seen as an action
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sel_local_ff <= 1'b0;
            sel_seen_ff  <= 2'h0;
        end
        else
        begin
            sel_local_ff <= sel_local_sync;
            if (!(&sel_seen_ff))
                sel_seen_ff <= sel_seen_ff + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    pmh_pkg::pmh_state_e state_ff;
    logic                take;
    logic                port_ok;
    logic                op_cmd;
    logic                start_ok;
    logic                stop_ok;
    logic                reset_ok;

    assign take   = cmd_valid && cmd_ready_ff;
    assign op_cmd = cmd_code == pmh_pkg::RUN_START_CMD ||
                    cmd_code == pmh_pkg::RUN_STOP_CMD ||
                    cmd_code == pmh_pkg::ALARM_RESET_CMD;

    // only the port that owns the serial mode may operate the pump
    assign port_ok = (mif.mode == pmh_pkg::MODE_SERIAL_232 &&
                      cmd_port == pmh_pkg::PORT_232) ||
                     (mif.mode == pmh_pkg::MODE_SERIAL_485 &&
                      cmd_port == pmh_pkg::PORT_485);

    assign start_ok = !pump_accel && !pump_normal && !fail_active;
    assign stop_ok  = pump_accel || pump_normal;
    assign reset_ok = fail_active || buzzer_on_ff;

    assign mif.online_req   = take && cmd_code == pmh_pkg::GO_ONLINE_CMD;
    assign mif.offline_req  = take && cmd_code == pmh_pkg::GO_OFFLINE_CMD;
    assign mif.req_port     = cmd_port;
    assign mif.panel_local  = (&sel_seen_ff) && sel_local_sync && !sel_local_ff;
    assign mif.panel_remote = (&sel_seen_ff) && !sel_local_sync && sel_local_ff;

    pmh_mode_ctl u_mode (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .mif      (mif)
    );

    function automatic logic [3:0] mode_ans(input pmh_pkg::pmh_mode_e m);
        unique case (m)
            pmh_pkg::MODE_LOCAL:      mode_ans = pmh_pkg::MODE_LOCAL_ANS;
            pmh_pkg::MODE_REMOTE:     mode_ans = pmh_pkg::MODE_REMOTE_ANS;
            pmh_pkg::MODE_SERIAL_232: mode_ans = pmh_pkg::MODE_SERIAL_232_ANS;
            pmh_pkg::MODE_SERIAL_485: mode_ans = pmh_pkg::MODE_SERIAL_485_ANS;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // answer generation
    // ----------------------------------------------------------------
    // an alarm reset needs one cycle for the cause to be re-evaluated
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ans_valid_ff <= 1'b0;
            ans_code_ff  <= pmh_pkg::MODE_REMOTE_ANS;
            ans_sub_ff   <= pmh_pkg::SUB_NONE;
        end
        else
        begin
            ans_valid_ff <= 1'b0;
            ans_sub_ff   <= pmh_pkg::SUB_NONE;
            if (state_ff == pmh_pkg::ST_CLEAR_WAIT)
            begin
                ans_valid_ff <= 1'b1;
                if (fail_cause)
                begin
                    ans_code_ff <= pmh_pkg::FAILURE_PERSISTS_ANS;
                    ans_sub_ff  <= fail_code;
                end
                else
                    ans_code_ff <= pmh_pkg::FAILURE_CLEARED_ANS;
            end
            else if (take)
            begin
                if (!op_cmd)
                begin
                    ans_valid_ff <= 1'b1;
                    ans_code_ff  <= mode_ans(mif.nxt_mode);
                end
                else if (!port_ok)
                begin
                    ans_valid_ff <= 1'b1;
                    ans_code_ff  <= pmh_pkg::OPERATION_INVALID_ANS;
                end
                else if (cmd_code == pmh_pkg::RUN_START_CMD)
                begin
                    ans_valid_ff <= 1'b1;
                    ans_code_ff  <= start_ok ? pmh_pkg::ACCEL_STARTED_ANS :
                                    pmh_pkg::OPERATION_INVALID_ANS;
                end
                else if (cmd_code == pmh_pkg::RUN_STOP_CMD)
                begin
                    ans_valid_ff <= 1'b1;
                    ans_code_ff  <= stop_ok ? pmh_pkg::DECEL_STARTED_ANS :
                                    pmh_pkg::OPERATION_INVALID_ANS;
                end
                else if (buzzer_on_ff)
                begin
                    ans_valid_ff <= 1'b1;
                    ans_code_ff  <= pmh_pkg::BUZZER_OFF_ANS;
                end
                else if (!reset_ok)
                begin
                    ans_valid_ff <= 1'b1;
                    ans_code_ff  <= pmh_pkg::OPERATION_INVALID_ANS;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // handler state and pump requests
    // ----------------------------------------------------------------
    logic do_clear;

    assign do_clear = take && op_cmd && port_ok && !buzzer_on_ff &&
                      cmd_code == pmh_pkg::ALARM_RESET_CMD && fail_active;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff     <= pmh_pkg::ST_IDLE;
            cmd_ready_ff <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                pmh_pkg::ST_IDLE:
                begin
                    if (do_clear)
                    begin
                        state_ff     <= pmh_pkg::ST_CLEAR_WAIT;
                        cmd_ready_ff <= 1'b0;
                    end
                    else
                        cmd_ready_ff <= 1'b1;
                end
                pmh_pkg::ST_CLEAR_WAIT:
                begin
                    state_ff     <= pmh_pkg::ST_IDLE;
                    cmd_ready_ff <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            start_req_ff   <= 1'b0;
            stop_req_ff    <= 1'b0;
            alarm_clear_ff <= 1'b0;
        end
        else
        begin
            start_req_ff   <= take && port_ok && start_ok &&
                              cmd_code == pmh_pkg::RUN_START_CMD;
            stop_req_ff    <= take && port_ok && stop_ok &&
                              cmd_code == pmh_pkg::RUN_STOP_CMD;
            alarm_clear_ff <= do_clear;
        end
    end

    // a new alarm in the silencing cycle keeps the buzzer sounding
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            buzzer_on_ff <= 1'b0;
        else if (alarm_event)
            buzzer_on_ff <= 1'b1;
        else if (state_ff == pmh_pkg::ST_CLEAR_WAIT && fail_cause)
            buzzer_on_ff <= 1'b1;
        else if (take && port_ok && cmd_code == pmh_pkg::ALARM_RESET_CMD)
            buzzer_on_ff <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            op_mode_ff <= pmh_pkg::MODE_RST;
        else
            op_mode_ff <= mif.nxt_mode;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_MODE_QUERY: assert property (
        take && cmd_code == pmh_pkg::MODE_QUERY_CMD |=>
            ans_valid_ff && ans_code_ff == mode_ans(pmh_pkg::pmh_mode_e'(op_mode_ff)))
        else $error("mode query answer does not match mode");

    AST_ONLINE_232: assert property (
        take && cmd_code == pmh_pkg::GO_ONLINE_CMD && cmd_port == pmh_pkg::PORT_232 &&
        mif.mode == pmh_pkg::MODE_REMOTE && !mif.panel_local && !mif.panel_remote |=>
            mif.mode == pmh_pkg::MODE_SERIAL_232 &&
            ans_code_ff == pmh_pkg::MODE_SERIAL_232_ANS)
        else $error("online via 232 did not enter 232 mode");

    AST_ONLINE_485: assert property (
        take && cmd_code == pmh_pkg::GO_ONLINE_CMD && cmd_port == pmh_pkg::PORT_485 &&
        mif.mode == pmh_pkg::MODE_REMOTE && !mif.panel_local && !mif.panel_remote |=>
            mif.mode == pmh_pkg::MODE_SERIAL_485 &&
            ans_code_ff == pmh_pkg::MODE_SERIAL_485_ANS)
        else $error("online via 485 did not enter 485 mode");

    AST_OFFLINE: assert property (
        mif.offline_req && !mif.panel_local && !mif.panel_remote &&
        (mif.mode == pmh_pkg::MODE_SERIAL_232 || mif.mode == pmh_pkg::MODE_SERIAL_485)
        |=> mif.mode == pmh_pkg::MODE_REMOTE)
        else $error("offline did not return to remote");

    AST_NO_EFFECT: assert property (
        mif.online_req && mif.mode != pmh_pkg::MODE_REMOTE &&
        !mif.panel_local && !mif.panel_remote |=> $stable(mif.mode))
        else $error("online changed mode outside remote");

    AST_PANEL: assert property (
        mif.panel_local |=> mif.mode == pmh_pkg::MODE_LOCAL)
        else $error("panel selector did not force local");

    AST_WRONG_PORT: assert property (
        take && op_cmd && !port_ok |=>
            ans_code_ff == pmh_pkg::OPERATION_INVALID_ANS && !start_req_ff &&
            !stop_req_ff && !alarm_clear_ff)
        else $error("operation from wrong port was not refused");

    AST_START: assert property (
        start_req_ff |-> ans_valid_ff && ans_code_ff == pmh_pkg::ACCEL_STARTED_ANS)
        else $error("start request without accel answer");

    AST_BUZZ_OFF: assert property (
        take && port_ok && cmd_code == pmh_pkg::ALARM_RESET_CMD && buzzer_on_ff &&
        !alarm_event |=> !buzzer_on_ff && ans_code_ff == pmh_pkg::BUZZER_OFF_ANS)
        else $error("reset did not silence the buzzer");

    AST_CLEAR_SEQ: assert property (
        alarm_clear_ff ##0 fail_cause |=>
            ans_code_ff == pmh_pkg::FAILURE_PERSISTS_ANS && buzzer_on_ff &&
            ans_sub_ff == $past(fail_code))
        else $error("persisting failure not reported");

    COV_ONLINE:  cover property (mif.online_req ##1 mif.mode == pmh_pkg::MODE_SERIAL_485);
    COV_START:   cover property (start_req_ff);
    COV_CLEARED: cover property (alarm_clear_ff ##1
                                 ans_code_ff == pmh_pkg::FAILURE_CLEARED_ANS);
    COV_INVALID: cover property (ans_valid_ff &&
                                 ans_code_ff == pmh_pkg::OPERATION_INVALID_ANS);

endmodule // pmh_cmd_handler

// File: design/pmh_pkg.sv
package pmh_pkg;

    // ----------------------------------------------------------------
    // operation modes and handler states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_LOCAL,
        MODE_REMOTE,
        MODE_SERIAL_232,
        MODE_SERIAL_485
    } pmh_mode_e;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_CLEAR_WAIT
    } pmh_state_e;

    // ----------------------------------------------------------------
    // command codes from the message framer
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_QUERY_CMD  = 3'h0;
    localparam logic [2:0] GO_ONLINE_CMD   = 3'h1;
    localparam logic [2:0] GO_OFFLINE_CMD  = 3'h2;
    localparam logic [2:0] RUN_START_CMD   = 3'h3;
    localparam logic [2:0] RUN_STOP_CMD    = 3'h4;
    localparam logic [2:0] ALARM_RESET_CMD = 3'h5;

    // ----------------------------------------------------------------
    // answer codes to the message framer
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_LOCAL_ANS        = 4'h0;
    localparam logic [3:0] MODE_REMOTE_ANS       = 4'h1;
    localparam logic [3:0] MODE_SERIAL_232_ANS   = 4'h2;
    localparam logic [3:0] MODE_SERIAL_485_ANS   = 4'h3;
    localparam logic [3:0] ACCEL_STARTED_ANS     = 4'h4;
    localparam logic [3:0] DECEL_STARTED_ANS     = 4'h5;
    localparam logic [3:0] BUZZER_OFF_ANS        = 4'h6;
    localparam logic [3:0] FAILURE_CLEARED_ANS   = 4'h7;
    localparam logic [3:0] FAILURE_PERSISTS_ANS  = 4'h8;
    localparam logic [3:0] OPERATION_INVALID_ANS = 4'h9;

    // ----------------------------------------------------------------
    // ports, field widths and reset values
    // ----------------------------------------------------------------
    localparam logic        PORT_232       = 1'b0;
    localparam logic        PORT_485       = 1'b1;
    localparam int          SUB_W          = 16;
    localparam logic [15:0] SUB_NONE       = 16'h0000;
    localparam pmh_mode_e   MODE_RST       = MODE_REMOTE;
    localparam int          SYNC_STAGES    = 2;

endpackage

// File: design/pmh_mode_if.sv
`timescale 1ns/1ps
interface pmh_mode_if;
    logic               online_req;
    logic               offline_req;
    logic               req_port;
    logic               panel_local;
    logic               panel_remote;
    pmh_pkg::pmh_mode_e nxt_mode;
    pmh_pkg::pmh_mode_e mode;

    modport ctl (
        input  online_req,
        input  offline_req,
        input  req_port,
        input  panel_local,
        input  panel_remote,
        output nxt_mode,
        output mode
    );

    modport user (
        output online_req,
        output offline_req,
        output req_port,
        output panel_local,
        output panel_remote,
        input  nxt_mode,
        input  mode
    );
endinterface

// File: design/pmh_sync.sv
`timescale 1ns/1ps
module pmh_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // ----------------------------------------------------------------
    // two-stage synchroniser, one per bit
    // ----------------------------------------------------------------
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                meta_ff[i] <= 1'b0;
                sync_ff[i] <= 1'b0;
            end
            else
            begin
                meta_ff[i] <= async_in[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end

    assign sync_out = sync_ff;

endmodule // pmh_sync

// File: design/pmh_mode_ctl.sv
`timescale 1ns/1ps
module pmh_mode_ctl (
    input  wire logic    core_clk,
    input  wire logic    arst_n,
    pmh_mode_if.ctl      mif
);

    // ----------------------------------------------------------------
    // operation mode register
    // ----------------------------------------------------------------
    pmh_pkg::pmh_mode_e mode_ff;
    pmh_pkg::pmh_mode_e nxt_mode;

    // panel selector beats serial requests in the same cycle
    always_comb
    begin
        nxt_mode = mode_ff;
        if (mif.panel_local)
            nxt_mode = pmh_pkg::MODE_LOCAL;
        else if (mif.panel_remote)
            nxt_mode = pmh_pkg::MODE_REMOTE;
        else if (mif.online_req && mode_ff == pmh_pkg::MODE_REMOTE)
            nxt_mode = (mif.req_port == pmh_pkg::PORT_485) ?
                       pmh_pkg::MODE_SERIAL_485 :
                       pmh_pkg::MODE_SERIAL_232;
        else if (mif.offline_req && (mode_ff == pmh_pkg::MODE_SERIAL_232 ||
                                     mode_ff == pmh_pkg::MODE_SERIAL_485))
            nxt_mode = pmh_pkg::MODE_REMOTE;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            mode_ff <= pmh_pkg::MODE_RST;
        else
            mode_ff <= nxt_mode;
    end

    assign mif.nxt_mode = nxt_mode;
    assign mif.mode     = mode_ff;

endmodule // pmh_mode_ctl

// File: verif/pmh_host_model.sv
`timescale 1ns/1ps
module pmh_host_model (
    input  wire logic        core_clk,
    input  wire logic        cmd_ready_ff,
    input  wire logic        ans_valid_ff,
    input  wire logic [3:0]  ans_code_ff,
    input  wire logic [15:0] ans_sub_ff,
    output logic             cmd_valid,
    output logic [2:0]       cmd_code,
    output logic             cmd_port
);
    // ----------------------------------------------------------------
    // one command at a time, held until taken or until 8 cycles pass without ready
    // ----------------------------------------------------------------
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code  = 3'h7;
        cmd_port  = 1'b0;
    end

    // a missing answer returns all ones so the caller sees a mismatch
    task automatic send(input logic [2:0] code, input logic port,
                        output logic [3:0] ans, output logic [15:0] sub);
        int n;
        n   = 0;
        ans = 4'hf;
        sub = 16'hffff;
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_code  = code;
        cmd_port  = port;
        while (cmd_ready_ff !== 1'b1 && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        // released lines must not keep showing the last command
        cmd_code  = ~code;
        cmd_port  = ~port;
        n = 0;
        while (ans_valid_ff !== 1'b1 && n < 4)
        begin
            @(negedge core_clk);
            n++;
        end
        if (ans_valid_ff === 1'b1)
        begin
            ans = ans_code_ff;
            sub = ans_sub_ff;
        end
    endtask
endmodule // pmh_host_model

// File: verif/pmh_cmd_handler_tb.sv
`timescale 1ns/1ps
module pmh_cmd_handler_tb;
    logic        core_clk, arst_n, cmd_valid, cmd_port, cmd_ready_ff, ans_valid_ff;
    logic [2:0]  cmd_code;
    logic [3:0]  ans_code_ff, a;
    logic [15:0] ans_sub_ff, fail_code, s;
    logic        panel_local_sel, pump_accel, pump_normal, fail_active, fail_cause;
    logic        alarm_event, start_req_ff, stop_req_ff, alarm_clear_ff, buzzer_on_ff;
    logic [1:0]  op_mode_ff;
    int          bad_count, samples_checked, n_start, n_stop, n_clear, n_busy;

    pmh_cmd_handler u_pmh_cmd_handler (.core_clk(core_clk), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_port(cmd_port),
        .cmd_ready_ff(cmd_ready_ff), .ans_valid_ff(ans_valid_ff), .ans_code_ff(ans_code_ff),
        .ans_sub_ff(ans_sub_ff), .panel_local_sel(panel_local_sel), .pump_accel(pump_accel),
        .pump_normal(pump_normal), .fail_active(fail_active), .fail_cause(fail_cause),
        .fail_code(fail_code), .alarm_event(alarm_event), .start_req_ff(start_req_ff),
        .stop_req_ff(stop_req_ff), .alarm_clear_ff(alarm_clear_ff),
        .buzzer_on_ff(buzzer_on_ff), .op_mode_ff(op_mode_ff));

    pmh_host_model u_pmh_host_model (.core_clk(core_clk), .cmd_ready_ff(cmd_ready_ff),
        .ans_valid_ff(ans_valid_ff), .ans_code_ff(ans_code_ff), .ans_sub_ff(ans_sub_ff),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_port(cmd_port));

    // ----------------------------------------------------------------
    // clock, pulse counters, helpers
    // ----------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    // pulses are counted as they rise, so a check right after the answer sees them
    always @(posedge start_req_ff) n_start++;
    always @(posedge stop_req_ff) n_stop++;
    always @(posedge alarm_clear_ff) n_clear++;

    // edges with the command port refused, reset release included
    always @(posedge core_clk)
        if (arst_n === 1'b1 && cmd_ready_ff === 1'b0) n_busy++;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic op(input logic [2:0] code, input logic port);
        u_pmh_host_model.send(code, port, a, s);
    endtask

    task automatic summarize();
        $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_remote();
        chk(16'(op_mode_ff), 16'h0001);
        op(pmh_pkg::MODE_QUERY_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::MODE_REMOTE_ANS));
        op(pmh_pkg::RUN_START_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::OPERATION_INVALID_ANS));
        chk(16'(n_start), 16'h0000);
        op(pmh_pkg::GO_OFFLINE_CMD, pmh_pkg::PORT_485);
        chk(16'(a), 16'(pmh_pkg::MODE_REMOTE_ANS));
        $display("test remote done");
    endtask

    task automatic t_run_485();
        op(pmh_pkg::GO_ONLINE_CMD, pmh_pkg::PORT_485);
        chk(16'(a), 16'(pmh_pkg::MODE_SERIAL_485_ANS));
        chk(16'(op_mode_ff), 16'h0003);
        op(pmh_pkg::GO_ONLINE_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::MODE_SERIAL_485_ANS));
        op(pmh_pkg::RUN_START_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::OPERATION_INVALID_ANS));
        op(pmh_pkg::RUN_START_CMD, pmh_pkg::PORT_485);
        chk(16'(a), 16'(pmh_pkg::ACCEL_STARTED_ANS));
        chk(16'(n_start), 16'h0001);
        pump_accel = 1'b1;
        op(pmh_pkg::RUN_START_CMD, pmh_pkg::PORT_485);
        chk(16'(a), 16'(pmh_pkg::OPERATION_INVALID_ANS));
        chk(16'(n_start), 16'h0001);
        pump_accel  = 1'b0;
        pump_normal = 1'b1;
        op(pmh_pkg::RUN_STOP_CMD, pmh_pkg::PORT_485);
        chk(16'(a), 16'(pmh_pkg::DECEL_STARTED_ANS));
        chk(16'(n_stop), 16'h0001);
        pump_normal = 1'b0;
        op(pmh_pkg::GO_OFFLINE_CMD, pmh_pkg::PORT_485);
        chk(16'(a), 16'(pmh_pkg::MODE_REMOTE_ANS));
        chk(16'(op_mode_ff), 16'h0001);
        $display("test run 485 done");
    endtask

    task automatic t_alarm_232();
        op(pmh_pkg::GO_ONLINE_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::MODE_SERIAL_232_ANS));
        fail_active = 1'b1;
        fail_cause  = 1'b1;
        fail_code   = 16'h3431;
        alarm_event = 1'b1;
        @(negedge core_clk);
        alarm_event = 1'b0;
        @(negedge core_clk);
        chk(16'(buzzer_on_ff), 16'h0001);
        op(pmh_pkg::ALARM_RESET_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::BUZZER_OFF_ANS));
        chk(16'(buzzer_on_ff + n_clear), 16'h0000);
        op(pmh_pkg::ALARM_RESET_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::FAILURE_PERSISTS_ANS));
        chk(s, 16'h3431);
        chk(16'(buzzer_on_ff), 16'h0001);
        chk(16'(n_clear), 16'h0001);
        op(pmh_pkg::ALARM_RESET_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::BUZZER_OFF_ANS));
        fail_cause = 1'b0;
        op(pmh_pkg::ALARM_RESET_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::FAILURE_CLEARED_ANS));
        chk(s, pmh_pkg::SUB_NONE);
        chk(16'(n_clear), 16'h0002);
        fail_active = 1'b0;
        op(pmh_pkg::ALARM_RESET_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::OPERATION_INVALID_ANS));
        chk(16'(n_busy), 16'h0003);
        $display("test alarm 232 done");
    endtask

    task automatic t_panel();
        panel_local_sel = 1'b1;
        repeat (8) @(negedge core_clk);
        chk(16'(op_mode_ff), 16'h0000);
        op(pmh_pkg::MODE_QUERY_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::MODE_LOCAL_ANS));
        op(pmh_pkg::GO_ONLINE_CMD, pmh_pkg::PORT_232);
        chk(16'(a), 16'(pmh_pkg::MODE_LOCAL_ANS));
        panel_local_sel = 1'b0;
        repeat (8) @(negedge core_clk);
        chk(16'(op_mode_ff), 16'h0001);
        $display("test panel done");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        {core_clk, arst_n, panel_local_sel, pump_accel, pump_normal} = 5'h00;
        {fail_active, fail_cause, alarm_event, fail_code} = 19'h0_0000;
        {bad_count, samples_checked, n_start, n_stop, n_clear, n_busy} = '0;
        repeat (20) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        t_remote();
        t_run_485();
        t_alarm_232();
        t_panel();
        summarize();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        #200000;
        bad_count++;
        $display("watchdog expired");
        summarize();
    end
endmodule // pmh_cmd_handler_tb
